/* design/pswin_pkg.sv */
/*
  Constants for the program-space data window: widths, bit positions,
  reset values and stall counts.
  Assumes a 16-bit data space and a 24-bit program word.
*/
package pswin_pkg;
  localparam int DATA_AW = 16;
  localparam int WIN_OFS_W = 15;
  localparam int PAGE_W = 8;
  localparam int PROG_AW = PAGE_W + WIN_OFS_W;
  localparam int PROG_DW = 24;
  localparam int DATA_DW = 16;
  localparam int CORE_CTRL_W = 16;
  localparam int WIN_EN_BIT = 2;
  localparam int WIN_SEL_BIT = DATA_AW - 1;
  localparam logic [CORE_CTRL_W-1:0] CORE_CTRL_RST = 16'h0000;
  localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;
  localparam logic [1:0] STALL_NONE = 2'h0;
  localparam logic [1:0] STALL_MOVE = 2'h1;
  localparam logic [1:0] STALL_OTHER = 2'h2;
  localparam logic [1:0] STALL_REPEAT_EDGE = 2'h2;
endpackage : pswin_pkg

/* design/pswin_stall.sv */
/*
  Stall-cycle calculator for window accesses, registered output.
  Assumes one request pulse per instruction from the core issue stage.
*/
`timescale 1ns/1ps
module pswin_stall (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Request
  input wire logic win_hit,
  input wire logic is_move,
  input wire logic in_repeat,
  input wire logic rpt_edge,
  // Result
  output logic [1:0] stall_cnt
);
  logic [1:0] stall_reg;
  logic [1:0] stall_next;

  always_comb begin
    stall_next = pswin_pkg::STALL_NONE;
    if (win_hit) begin
      if (in_repeat) begin
        stall_next = rpt_edge ? pswin_pkg::STALL_REPEAT_EDGE : pswin_pkg::STALL_NONE; // [RULE9] [RULE10]
      end else begin
        stall_next = is_move ? pswin_pkg::STALL_MOVE : pswin_pkg::STALL_OTHER; // [RULE8]
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stall_reg <= pswin_pkg::STALL_NONE;
    end else begin
      stall_reg <= stall_next;
    end
  end

  assign stall_cnt = stall_reg;
endmodule : pswin_stall

/* design/pswin_top.sv */
/*
  Program-space data window: maps the upper data half onto a program page.
  Assumes the core supplies one access request per cycle with effective
  address, instruction class and repeat-loop status on the same clock.
*/
// Functional notes
// [RULE1] Window used only when address top bit and enable bit 2 both set.
// [RULE2] Upper 32 Kbytes of data space overlay any 16K-word program page.
// [RULE3] Eight-bit page select chooses one of 256 pages.
// [RULE4] Program address is page select above low 15 address bits.
// [RULE5] Window reads return low 16 bits of the 24-bit program word.
// [RULE6] Window read stalls by an extra cycle for two fetches.
// [RULE7] Window accesses suspended during table read or write.
// [RULE8] Outside repeat: moves add one cycle, others add two.
// [RULE9] In repeat: first, last, interrupt exit and resume add two cycles.
// [RULE10] Other repeat iterations run single cycle, no stall.
// [RULE11] Disabled or low half goes to data memory, no stall.
// [RULE12] Enable bit and page select reset to zero.
`timescale 1ns/1ps
module pswin_top (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control writes from core
  input wire logic ctrl_we,
  input wire logic [pswin_pkg::CORE_CTRL_W-1:0] ctrl_wdata,
  input wire logic page_we,
  input wire logic [pswin_pkg::PAGE_W-1:0] page_wdata,
  // Data access
  input wire logic acc_valid,
  input wire logic [pswin_pkg::DATA_AW-1:0] data_effective_address,
  input wire logic table_read_instr,
  input wire logic move_double_instr,
  input wire logic in_repeat,
  input wire logic rpt_first,
  input wire logic rpt_last,
  input wire logic rpt_irq_exit,
  input wire logic rpt_irq_resume,
  // Program memory return
  input wire logic [pswin_pkg::PROG_DW-1:0] prog_rdata,
  // Outputs
  output logic program_window_enable,
  output logic [pswin_pkg::PAGE_W-1:0] program_page_select,
  output logic prog_req,
  output logic [pswin_pkg::PROG_AW-1:0] prog_addr,
  output logic data_req,
  output logic [pswin_pkg::DATA_AW-1:0] data_addr,
  output logic [pswin_pkg::DATA_DW-1:0] win_rdata,
  output logic [1:0] stall_cycles
);
  logic [pswin_pkg::CORE_CTRL_W-1:0] core_control_reg;
  logic [pswin_pkg::CORE_CTRL_W-1:0] core_control_next;
  logic [pswin_pkg::PAGE_W-1:0] page_reg;
  logic [pswin_pkg::PAGE_W-1:0] page_next;
  logic prog_req_reg;
  logic prog_req_next;
  logic [pswin_pkg::PROG_AW-1:0] prog_addr_reg;
  logic [pswin_pkg::PROG_AW-1:0] prog_addr_next;
  logic data_req_reg;
  logic data_req_next;
  logic [pswin_pkg::DATA_AW-1:0] data_addr_reg;
  logic [pswin_pkg::DATA_AW-1:0] data_addr_next;
  logic [pswin_pkg::DATA_DW-1:0] rdata_reg;
  logic [pswin_pkg::DATA_DW-1:0] rdata_next;
  logic win_hit;
  logic rpt_edge;

  function automatic logic [pswin_pkg::PROG_AW-1:0] prog_map(
    input logic [pswin_pkg::PAGE_W-1:0] pg,
    input logic [pswin_pkg::DATA_AW-1:0] ea
  );
    prog_map = {pg, ea[pswin_pkg::WIN_OFS_W-1:0]}; // [RULE2] [RULE4]
  endfunction : prog_map

  function automatic logic ea_top(input logic [pswin_pkg::DATA_AW-1:0] ea);
    ea_top = ea[pswin_pkg::WIN_SEL_BIT];
  endfunction : ea_top

  // Window decode; table instructions own program memory meanwhile
  assign win_hit = acc_valid && ea_top(data_effective_address) &&
                   core_control_reg[pswin_pkg::WIN_EN_BIT] && !table_read_instr; // [RULE1] [RULE7]
  assign rpt_edge = rpt_first | rpt_last | rpt_irq_exit | rpt_irq_resume;

  always_comb begin
    core_control_next = core_control_reg;
    page_next = page_reg;
    if (ctrl_we) begin
      core_control_next = ctrl_wdata;
    end
    if (page_we) begin
      page_next = page_wdata; // [RULE3]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_control_reg <= pswin_pkg::CORE_CTRL_RST; // [RULE12]
      page_reg <= pswin_pkg::PAGE_RST; // [RULE12]
    end else begin
      core_control_reg <= core_control_next;
      page_reg <= page_next;
    end
  end

  always_comb begin
    prog_req_next = 1'b0;
    prog_addr_next = prog_addr_reg;
    data_req_next = 1'b0;
    data_addr_next = data_addr_reg;
    rdata_next = rdata_reg;
    if (win_hit) begin
      prog_req_next = 1'b1;
      prog_addr_next = prog_map(page_reg, data_effective_address); // [RULE4]
    end else if (acc_valid && !table_read_instr) begin
      data_req_next = 1'b1; // [RULE11]
      data_addr_next = data_effective_address;
    end
    // Upper byte of the program word is dropped; it holds no data
    if (prog_req_reg) begin
      rdata_next = prog_rdata[pswin_pkg::DATA_DW-1:0]; // [RULE5]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_req_reg <= 1'b0;
      prog_addr_reg <= '0;
      data_req_reg <= 1'b0;
      data_addr_reg <= '0;
      rdata_reg <= '0;
    end else begin
      prog_req_reg <= prog_req_next;
      prog_addr_reg <= prog_addr_next;
      data_req_reg <= data_req_next;
      data_addr_reg <= data_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // Stall count lands in the same cycle as prog_req
  pswin_stall u_stall (
    .clk(clk),
    .arst_n(arst_n),
    .win_hit(win_hit),
    .is_move(move_double_instr),
    .in_repeat(in_repeat),
    .rpt_edge(rpt_edge),
    .stall_cnt(stall_cycles) // [RULE6]
  );

  assign program_window_enable = core_control_reg[pswin_pkg::WIN_EN_BIT];
  assign program_page_select = page_reg;
  assign prog_req = prog_req_reg;
  assign prog_addr = prog_addr_reg;
  assign data_req = data_req_reg;
  assign data_addr = data_addr_reg;
  assign win_rdata = rdata_reg;

  // Checks
  sequence s_win_access;
    acc_valid && data_effective_address[pswin_pkg::WIN_SEL_BIT] &&
      program_window_enable && !table_read_instr;
  endsequence

  sequence s_prog_issue;
    prog_req && prog_addr[pswin_pkg::WIN_OFS_W-1:0] ==
      $past(data_effective_address[pswin_pkg::WIN_OFS_W-1:0]);
  endsequence

  a_window_route: assert property (@(posedge clk) disable iff (!arst_n) // [RULE1]
    s_win_access |=> s_prog_issue)
    else $error("window access not sent to program memory");

  a_page_addr: assert property (@(posedge clk) disable iff (!arst_n) // [RULE4]
    win_hit |=> prog_addr[pswin_pkg::PROG_AW-1:pswin_pkg::WIN_OFS_W] == $past(page_reg))
    else $error("page bits wrong in program address");

  a_rdata_low: assert property (@(posedge clk) disable iff (!arst_n) // [RULE5]
    prog_req |=> win_rdata == $past(prog_rdata[pswin_pkg::DATA_DW-1:0]))
    else $error("window read data not low 16 bits");

  a_table_block: assert property (@(posedge clk) disable iff (!arst_n) // [RULE7]
    table_read_instr |=> !prog_req && !data_req)
    else $error("access during table instruction");

  a_move_stall: assert property (@(posedge clk) disable iff (!arst_n) // [RULE8]
    win_hit && !in_repeat |=> stall_cycles ==
      ($past(move_double_instr) ? pswin_pkg::STALL_MOVE : pswin_pkg::STALL_OTHER))
    else $error("wrong stall outside repeat");

  a_rpt_edge: assert property (@(posedge clk) disable iff (!arst_n) // [RULE9]
    win_hit && in_repeat && rpt_edge |=> stall_cycles == pswin_pkg::STALL_REPEAT_EDGE)
    else $error("repeat edge iteration not two cycles");

  a_rpt_mid: assert property (@(posedge clk) disable iff (!arst_n) // [RULE10]
    win_hit && in_repeat && !rpt_edge |=> stall_cycles == pswin_pkg::STALL_NONE && prog_req)
    else $error("mid repeat iteration stalled");

  a_data_path: assert property (@(posedge clk) disable iff (!arst_n) // [RULE11]
    acc_valid && !table_read_instr && !win_hit |=>
      data_req && !prog_req && stall_cycles == pswin_pkg::STALL_NONE)
    else $error("data memory access mishandled");

  a_window_stall: assert property (@(posedge clk) disable iff (!arst_n) // [RULE6]
    win_hit && !in_repeat |=> stall_cycles != pswin_pkg::STALL_NONE)
    else $error("window read without stall");

  a_reset_off: assert property (@(posedge clk) // [RULE12]
    $rose(arst_n) |-> !program_window_enable && program_page_select == pswin_pkg::PAGE_RST)
    else $error("window not cleared by reset");

  a_enable_write: assert property (@(posedge clk) disable iff (!arst_n) // [RULE1]
    ctrl_we |=> program_window_enable == $past(ctrl_wdata[pswin_pkg::WIN_EN_BIT]))
    else $error("window enable bit not written");

  a_page_write: assert property (@(posedge clk) disable iff (!arst_n) // [RULE3]
    page_we |=> program_page_select == $past(page_wdata))
    else $error("page select not written");

  a_one_path: assert property (@(posedge clk) disable iff (!arst_n) // [RULE11]
    !(prog_req && data_req))
    else $error("access sent to both memories");
endmodule : pswin_top

/* verif/pswin_prog_mem.sv */
/*
  Program memory model behind the window.
  Assumes prog_rdata is sampled while prog_req is high.
*/
`timescale 1ns/1ps
module pswin_prog_mem (
  // Clock
  input wire logic clk,
  // Request
  input wire logic prog_req,
  input wire logic [pswin_pkg::PROG_AW-1:0] prog_addr,
  // Word out
  output logic [pswin_pkg::PROG_DW-1:0] prog_rdata
);
  logic [23:0] junk_reg = 24'h000000;
  // Idle value keeps moving so stale data never matches
  always_ff @(posedge clk) begin
    junk_reg <= junk_reg + 24'h5A5A5B;
  end
  // Upper byte nonzero for the pages used, to catch a missing mask
  assign prog_rdata = prog_req ? {prog_addr[22:15] ^ 8'h5A, prog_addr[15:0] ^ 16'hC3A5} :
                      junk_reg;
endmodule : pswin_prog_mem

/* verif/testbench.sv */
/*
  Self-checking bench for the program-space data window.
  Assumes pswin_top and the program memory model beside it.
*/
`timescale 1ns/1ps
module testbench;
  logic clk, arst_n, ctrl_we, page_we, acc_valid, tbl, mv, rpt;
  logic [3:0] rf;
  logic [15:0] ctrl_wdata, ea, data_addr, win_rdata;
  logic [7:0] page_wdata, pg, program_page_select;
  logic [23:0] prog_rdata;
  logic [22:0] prog_addr;
  logic program_window_enable, prog_req, data_req;
  logic [1:0] stall_cycles;
  int fails, checked, cyc;

  pswin_top u_dut (.clk(clk), .arst_n(arst_n), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata),
    .page_we(page_we), .page_wdata(page_wdata), .acc_valid(acc_valid),
    .data_effective_address(ea), .table_read_instr(tbl), .move_double_instr(mv),
    .in_repeat(rpt), .rpt_first(rf[0]), .rpt_last(rf[1]), .rpt_irq_exit(rf[2]),
    .rpt_irq_resume(rf[3]), .prog_rdata(prog_rdata),
    .program_window_enable(program_window_enable),
    .program_page_select(program_page_select), .prog_req(prog_req),
    .prog_addr(prog_addr), .data_req(data_req), .data_addr(data_addr),
    .win_rdata(win_rdata), .stall_cycles(stall_cycles));
  pswin_prog_mem u_mem (.clk(clk), .prog_req(prog_req), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Other control bits set, so only bit 2 may matter
  task automatic set_win(input logic en, input logic [7:0] p);
    @(posedge clk);
    ctrl_we <= 1'b1;
    ctrl_wdata <= en ? 16'hFFFF : 16'hFFFB;
    page_we <= 1'b1;
    page_wdata <= p;
    @(posedge clk);
    ctrl_we <= 1'b0;
    page_we <= 1'b0;
    #1;
    chk(program_window_enable, en);
    chk(program_page_select, p);
    pg = p;
  endtask : set_win

  task automatic access(input logic [15:0] a, input logic t, input logic m,
      input logic r, input logic [3:0] f, input logic hit, input logic [1:0] st);
    @(posedge clk);
    acc_valid <= 1'b1;
    ea <= a;
    tbl <= t;
    mv <= m;
    rpt <= r;
    rf <= f;
    @(posedge clk);
    acc_valid <= 1'b0;
    tbl <= 1'b0;
    rf <= 4'h0;
    #1;
    chk(prog_req, hit);
    chk(data_req, !hit && !t);
    chk(stall_cycles, st);
    if (hit) begin
      chk(prog_addr, {pg, a[14:0]});
      @(posedge clk);
      #1;
      chk(win_rdata, {pg[0], a[14:0]} ^ 16'hC3A5);
    end else if (!t) begin
      chk(data_addr, a);
    end
  endtask : access

  task automatic t_reset;
    chk({program_window_enable, program_page_select}, 9'h000);
    chk({prog_req, data_req}, 2'h0);
    chk({stall_cycles, win_rdata}, 18'h00000);
  endtask : t_reset

  task automatic t_disabled;
    set_win(1'b0, 8'hA5);
    access(16'h8123, 0, 0, 0, 4'h0, 0, 2'h0);
  endtask : t_disabled

  task automatic t_pages;
    set_win(1'b1, 8'hA5);
    access(16'h8000, 0, 0, 0, 4'h0, 1, 2'h2);
    access(16'h7FFF, 0, 0, 0, 4'h0, 0, 2'h0);
    set_win(1'b1, 8'hFF);
    access(16'hFFFF, 0, 0, 0, 4'h0, 1, 2'h2);
    set_win(1'b1, 8'h00);
    access(16'hC001, 0, 0, 0, 4'h0, 1, 2'h2);
  endtask : t_pages

  task automatic t_stalls;
    set_win(1'b1, 8'h3C);
    access(16'h9000, 0, 1, 0, 4'h0, 1, 2'h1);
    access(16'h1000, 0, 1, 0, 4'h0, 0, 2'h0);
    for (int i = 0; i < 4; i++) begin
      access(16'hA002, 0, 0, 1, 4'h1 << i, 1, 2'h2);
    end
    access(16'hA004, 0, 0, 1, 4'h0, 1, 2'h0);
    access(16'hA006, 0, 1, 1, 4'h0, 1, 2'h0);
  endtask : t_stalls

  task automatic t_table;
    access(16'h8000, 1, 0, 0, 4'h0, 0, 2'h0);
    access(16'h8010, 0, 0, 0, 4'h0, 1, 2'h2);
  endtask : t_table

  // Mid-run reset must drop an enabled window
  task automatic t_reset_mid;
    set_win(1'b1, 8'h5A);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    access(16'h8000, 0, 0, 0, 4'h0, 0, 2'h0);
  endtask : t_reset_mid

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, well above the run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    {arst_n, ctrl_we, page_we, acc_valid, tbl, mv, rpt} = 7'h00;
    {rf, ctrl_wdata, ea, page_wdata} = 44'h0;
    pg = 8'h00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_disabled();
    t_pages();
    t_stalls();
    t_table();
    t_reset_mid();
    give_verdict();
  end
endmodule : testbench
